// *** src/pcp_pkg.sv ***
// Package for the configuration and I/O proxy initiator: map, fields, codes, carriers
package pcp_pkg;

    // Register byte offsets on the register bus
    localparam logic [7:0] PCP_OFF_DATA    = 8'h00;
    localparam logic [7:0] PCP_OFF_ADDRESS = 8'h04;
    localparam logic [7:0] PCP_OFF_COMMAND = 8'h08;
    localparam logic [7:0] PCP_OFF_MSTCFG  = 8'h0c;
    localparam int         PCP_DEC_W       = 8;

    // Register selector after decode
    typedef enum logic [2:0]
    {
        PCP_SEL_DATA    = 3'b000,
        PCP_SEL_ADDRESS = 3'b001,
        PCP_SEL_COMMAND = 3'b010,
        PCP_SEL_MSTCFG  = 3'b011,
        PCP_SEL_NONE    = 3'b100
    } pcp_sel_e;

    // Command register fields
    localparam int CMD_READY_BIT = 31;
    localparam int CMD_BE_HI     = 7;
    localparam int CMD_BE_LO     = 4;
    localparam int CMD_TYPE_BIT  = 2;
    localparam int CMD_RDWR_BIT  = 0;

    // Master configuration fields
    localparam int MCFG_CFG_FLUSH_BIT = 10;
    localparam int MCFG_IO_FLUSH_BIT  = 9;

    // Reset values, and the read data of a master abort
    localparam logic [31:0] PCP_DATA_RST    = 32'h0000_0000;
    localparam logic [31:0] PCP_ADDRESS_RST = 32'h0000_0000;
    localparam logic [3:0]  PCP_BE_RST      = 4'h0;
    localparam logic        PCP_READY_RST   = 1'b1;
    localparam logic [31:0] PCP_ABORT_DATA  = 32'hffff_ffff;

    // Bus command codes
    localparam logic [3:0] PCP_BUS_IO_RD  = 4'h2;
    localparam logic [3:0] PCP_BUS_IO_WR  = 4'h3;
    localparam logic [3:0] PCP_BUS_CFG_RD = 4'ha;
    localparam logic [3:0] PCP_BUS_CFG_WR = 4'hb;

    // Cycles a target has to claim a data phase before a master abort
    localparam int PCP_DEVSEL_TIMEOUT = 5;

    // Link-side state
    typedef enum logic [1:0]
    {
        PCP_IDLE = 2'b00,
        PCP_ADDR = 2'b01,
        PCP_DATA = 2'b10,
        PCP_TURN = 2'b11
    } pcp_state_e;

    // Pins driven toward the targets
    typedef struct packed
    {
        logic [31:0] ad;
        logic        ad_oe;
        logic [3:0]  cbe_n;
        logic        cbe_oe;
        logic        frame_n;
        logic        frame_oe;
        logic        irdy_n;
        logic        irdy_oe;
    } pcp_pci_out_s;

    // Pins sampled from the link
    typedef struct packed
    {
        logic        clk;
        logic [31:0] ad;
        logic        trdy_n;
        logic        devsel_n;
        logic        stop_n;
    } pcp_pci_in_s;

endpackage

// *** src/pcp_proxy.sv ***
// Proxy initiator: register port on AHB-Lite, single config or I/O cycles on the bus
module pcp_proxy
    import pcp_pkg::*;
#(
    parameter int DEVSEL_TIMEOUT = pcp_pkg::PCP_DEVSEL_TIMEOUT
) (
    // Clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic [31:0]                hrdata,
    output logic                       hresp,
    // Bus mastering permission from the command/status logic
    input  wire logic                  bus_master_enable,
    // Link pins
    input  wire pcp_pkg::pcp_pci_in_s  pci_in,
    output pcp_pkg::pcp_pci_out_s      pci_out
);

    import pcp_pkg::*;

    localparam int CNT_W = 3;

    initial
    begin
        if (DEVSEL_TIMEOUT < 1 || DEVSEL_TIMEOUT > 7)
            $error("pcp_proxy: DEVSEL_TIMEOUT must lie in 1..7");
    end

    typedef struct packed
    {
        // Data phase bookkeeping of the register bus
        logic         dp_wr;
        pcp_sel_e     dp_sel;
        logic [31:0]  hrdata;
        // Software-visible registers
        logic [31:0]  data;
        logic [31:0]  address;
        logic [3:0]   byte_en;
        logic         io_type;
        logic         rd_wr;
        logic         ready;
        logic         cfg_flush;
        logic         io_flush;
        // Link engine
        logic         pending;
        logic         retry;
        pcp_state_e   state;
        logic [CNT_W-1:0] wait_cnt;
        pcp_pci_in_s  pin_d;
        pcp_pci_out_s pout;
    } pcp_state_s;

    pcp_state_s  st_reg;
    pcp_state_s  st_next;
    pcp_pci_in_s pin_s;

    // Map a byte address onto a register selector
    function automatic pcp_sel_e pcp_decode(input logic [31:0] addr);
        pcp_sel_e sel;
        sel = PCP_SEL_NONE;
        if (addr[31:PCP_DEC_W] == '0)
        begin
            case (addr[PCP_DEC_W-1:0])
                PCP_OFF_DATA:    sel = PCP_SEL_DATA;
                PCP_OFF_ADDRESS: sel = PCP_SEL_ADDRESS;
                PCP_OFF_COMMAND: sel = PCP_SEL_COMMAND;
                PCP_OFF_MSTCFG:  sel = PCP_SEL_MSTCFG;
                default:         sel = PCP_SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    // Readback of one register; unmapped reads as zero
    function automatic logic [31:0] pcp_read(input pcp_sel_e sel, input pcp_state_s s);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (sel)
            PCP_SEL_DATA:    v = s.data;
            PCP_SEL_ADDRESS: v = s.address;
            PCP_SEL_COMMAND:
            begin
                v[CMD_READY_BIT]          = s.ready;
                v[CMD_BE_HI:CMD_BE_LO]    = s.byte_en;
                v[CMD_TYPE_BIT]           = s.io_type;
                v[CMD_RDWR_BIT]           = s.rd_wr;
            end
            PCP_SEL_MSTCFG:
            begin
                v[MCFG_CFG_FLUSH_BIT]     = s.cfg_flush;
                v[MCFG_IO_FLUSH_BIT]      = s.io_flush;
            end
            default:         v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // Bus command code from space and direction
    function automatic logic [3:0] pcp_bus_cmd(input logic io, input logic rd);
        logic [3:0] c;
        if (io)
            c = rd ? PCP_BUS_IO_RD : PCP_BUS_IO_WR;
        else
            c = rd ? PCP_BUS_CFG_RD : PCP_BUS_CFG_WR;
        return c;
    endfunction

    // Link clock and target responses come from another domain
    pcp_sync #(
        .WIDTH ($bits(pcp_pci_in_s))
    ) u_pin_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (pci_in),
        .sync_out (pin_s)
    );

    always_comb
    begin
        logic        tick;
        logic        start_ok;
        logic        flush;
        pcp_sel_e    rd_sel;
        pcp_pci_in_s smp;

        st_next  = st_reg;
        // Inputs are taken from the sample just before the link clock rose,
        // so data that changes right after the edge is never picked up
        smp      = st_reg.pin_d;
        tick     = pin_s.clk & ~st_reg.pin_d.clk;
        st_next.pin_d = pin_s;
        start_ok = 1'b0;
        flush    = 1'b0;
        rd_sel   = PCP_SEL_NONE;

        // Register writes in the data phase
        if (st_reg.dp_wr)
        begin
            case (st_reg.dp_sel)
                PCP_SEL_DATA:    st_next.data = hwdata;
                PCP_SEL_ADDRESS: st_next.address = hwdata;
                PCP_SEL_COMMAND:
                begin
                    // A command while busy is dropped; software must poll first
                    if (st_reg.ready)
                    begin
                        st_next.byte_en = hwdata[CMD_BE_HI:CMD_BE_LO];
                        st_next.io_type = hwdata[CMD_TYPE_BIT];
                        st_next.rd_wr   = hwdata[CMD_RDWR_BIT];
                        st_next.pending = 1'b1;
                        st_next.retry   = 1'b0;
                        st_next.ready   = 1'b0;
                    end
                end
                PCP_SEL_MSTCFG:
                begin
                    st_next.cfg_flush = hwdata[MCFG_CFG_FLUSH_BIT];
                    st_next.io_flush  = hwdata[MCFG_IO_FLUSH_BIT];
                end
                default:         st_next.dp_wr = st_reg.dp_wr;
            endcase
        end

        // Address phase capture; only single word transfers are expected
        st_next.dp_wr = 1'b0;
        if (hready && hsel && htrans[1])
        begin
            st_next.dp_wr  = hwrite;
            st_next.dp_sel = pcp_decode(haddr);
            if (!hwrite)
                rd_sel = pcp_decode(haddr);
        end

        // Link engine, advancing once per rising link clock edge
        if (tick)
        begin
            case (st_reg.state)
                PCP_IDLE:
                begin
                    start_ok = st_reg.pending && bus_master_enable;
                    flush    = st_reg.pending && !bus_master_enable &&
                               (st_reg.io_type ? st_reg.io_flush
                                               : st_reg.cfg_flush);
                    if (start_ok)
                    begin
                        st_next.state          = PCP_ADDR;
                        st_next.pout.frame_n   = 1'b0;
                        st_next.pout.frame_oe  = 1'b1;
                        st_next.pout.irdy_n    = 1'b1;
                        st_next.pout.irdy_oe   = 1'b1;
                        st_next.pout.ad_oe     = 1'b1;
                        st_next.pout.cbe_oe    = 1'b1;
                        st_next.pout.cbe_n     = pcp_bus_cmd(st_reg.io_type, st_reg.rd_wr);
                        if (st_reg.io_type)
                            st_next.pout.ad    = st_reg.address;
                        else
                            st_next.pout.ad    = {st_reg.address[31:2], 2'b00};
                    end
                    else if (flush)
                    begin
                        // Discarded command: nothing reaches the bus
                        st_next.pending = 1'b0;
                        st_next.ready   = 1'b1;
                    end
                end
                PCP_ADDR:
                begin
                    // Single data phase: frame drops with irdy asserted
                    st_next.state        = PCP_DATA;
                    st_next.wait_cnt     = '0;
                    st_next.pout.frame_n = 1'b1;
                    st_next.pout.irdy_n  = 1'b0;
                    st_next.pout.cbe_n   = ~st_reg.byte_en;
                    if (st_reg.rd_wr)
                        st_next.pout.ad_oe = 1'b0; // Turnaround for the target
                    else
                        st_next.pout.ad    = st_reg.data;
                end
                PCP_DATA:
                begin
                    if (!smp.devsel_n && !smp.trdy_n)
                    begin
                        if (st_reg.rd_wr)
                            st_next.data = smp.ad;
                        st_next.retry = 1'b0;
                        st_next.state = PCP_TURN;
                    end
                    else if (!smp.devsel_n && !smp.stop_n)
                    begin
                        // Target asked to try again later: reissue from idle
                        st_next.retry = 1'b1;
                        st_next.state = PCP_TURN;
                    end
                    else if (smp.devsel_n &&
                             st_reg.wait_cnt == CNT_W'(DEVSEL_TIMEOUT - 1))
                    begin
                        // Nobody claimed the cycle: master abort, reads give all ones
                        if (st_reg.rd_wr)
                            st_next.data = PCP_ABORT_DATA;
                        st_next.retry = 1'b0;
                        st_next.state = PCP_TURN;
                    end
                    else if (smp.devsel_n)
                    begin
                        st_next.wait_cnt = st_reg.wait_cnt + CNT_W'(1);
                    end
                    if (st_next.state == PCP_TURN)
                    begin
                        st_next.pout.irdy_n = 1'b1;
                        st_next.pout.ad_oe  = 1'b0;
                        st_next.pout.cbe_oe = 1'b0;
                    end
                end
                PCP_TURN:
                begin
                    // Irdy was driven high for one cycle, frame since the data phase began; now let go
                    st_next.state         = PCP_IDLE;
                    st_next.pout.frame_oe = 1'b0;
                    st_next.pout.irdy_oe  = 1'b0;
                    if (!st_reg.retry)
                    begin
                        // Data is already stored before ready rises
                        st_next.pending = 1'b0;
                        st_next.ready   = 1'b1;
                    end
                end
                default:
                begin
                    st_next.state = PCP_IDLE;
                end
            endcase
        end

        // Read data from the updated copy, so a write just before is seen
        if (rd_sel != PCP_SEL_NONE)
            st_next.hrdata = pcp_read(rd_sel, st_next);
        else
            st_next.hrdata = 32'h0000_0000;
    end

    // All state in one register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_reg              <= '0;
            st_reg.dp_sel       <= PCP_SEL_NONE;
            st_reg.data         <= PCP_DATA_RST;
            st_reg.address      <= PCP_ADDRESS_RST;
            st_reg.byte_en      <= PCP_BE_RST;
            st_reg.ready        <= PCP_READY_RST;
            st_reg.state        <= PCP_IDLE;
            st_reg.pout.frame_n <= 1'b1;
            st_reg.pout.irdy_n  <= 1'b1;
            st_reg.pout.cbe_n   <= 4'hf;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Zero wait state slave; every answer is OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st_reg.hrdata;
    assign pci_out   = st_reg.pout;

endmodule

// *** src/pcp_sync.sv ***
// Two-flop synchroniser for a group of inputs from outside the clock domain
module pcp_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // Asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed
    {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } pcp_sync_s;

    pcp_sync_s st_reg;
    pcp_sync_s st_next;

    initial
    begin
        if (WIDTH < 1)
            $error("pcp_sync: WIDTH must be at least 1");
    end

    // The first stage feeds only the second stage
    always_comb
    begin
        st_next.meta = async_in;
        st_next.sync = st_reg.meta;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign sync_out = st_reg.sync;

endmodule

// *** test/pcp_proxy_bench.sv ***
// Self-checking bench for the proxy initiator with a target model on the link
module pcp_proxy_bench
    import pcp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, lclk = 1'h0;
    logic         bus_master_enable = 1'h1, present = 1'h1;
    logic [1:0]   htrans = 2'h0, lat = 2'h0;
    logic [2:0]   hsize = 3'h2;
    logic [31:0]  haddr = 32'h0, hwdata = 32'h0, rdata = 32'h0, rd, ed, hrdata, m_ad, g_addr, g_wd;
    logic         hreadyout, hresp, trdy_n, devsel_n, stop_n;
    logic [3:0]   g_cmd, g_be;
    pcp_pci_out_s pout;
    pcp_pci_in_s  pin;
    int           frames, f0, n_fail = 0, checks = 0;

    // Link data lines resolve between initiator and target
    assign pin = '{lclk, pout.ad_oe ? pout.ad : m_ad, trdy_n, devsel_n, stop_n};

    // System clock, and an unrelated slower link clock
    always #20 hclk = ~hclk;
    initial
    begin
        #7;
        forever #160 lclk = ~lclk;
    end

    pcp_proxy #(.DEVSEL_TIMEOUT(3)) pcp_proxy_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
        .bus_master_enable, .pci_in(pin), .pci_out(pout));
    pcp_target_model pcp_target_model_inst (.lclk, .pins(pout), .present, .lat, .rdata, .trdy_n,
        .devsel_n, .stop_n, .ad(m_ad), .got_addr(g_addr), .got_wd(g_wd), .got_cmd(g_cmd),
        .got_be(g_be), .frames);

    task automatic report_and_stop();
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // One single transfer; holds each phase until hready is seen high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
        // Every answer is ready and OKAY, busy or not
        chk({30'h0, hreadyout, hresp}, 32'h2);
    endtask

    // Poll the command register until it reports ready (bounded)
    task automatic wait_ready();
        int k;
        k = 0;
        do
        begin
            bus(1'h0, PCP_OFF_COMMAND, 32'h0);
            k++;
        end
        while (rd[CMD_READY_BIT] !== 1'h1 && k < 400);
    endtask

    // Full proxy transaction in software order, then compare what the target saw
    task automatic run(input logic t, input logic r, input logic [3:0] be, input logic [31:0] a,
        input logic [31:0] d);
        logic [31:0] c;
        c = {24'h0, be, 1'h0, t, 1'h0, r};
        f0 = frames;
        if (!r)
            bus(1'h1, PCP_OFF_DATA, d);
        bus(1'h1, PCP_OFF_ADDRESS, a);
        repeat (24) @(posedge hclk);
        chk(frames, f0);
        bus(1'h1, PCP_OFF_COMMAND, c);
        bus(1'h0, PCP_OFF_COMMAND, 32'h0);
        chk(rd, c);
        wait_ready();
        chk(rd, c | 32'h8000_0000);
        chk(frames, f0 + 1);
        chk(g_addr, t ? a : {a[31:2], 2'h0});
        chk({28'h0, g_cmd}, {28'h0, t ? (r ? PCP_BUS_IO_RD : PCP_BUS_IO_WR)
            : (r ? PCP_BUS_CFG_RD : PCP_BUS_CFG_WR)});
        if (present)
            chk({28'h0, g_be}, {28'h0, be});
        if (!r)
            chk(g_wd, d);
        ed = !r ? d : present ? rdata : PCP_ABORT_DATA;
        bus(1'h0, PCP_OFF_DATA, 32'h0);
        chk(rd, ed);
    endtask

    // Watchdog: far beyond the several hundred cycles the tests need
    initial
    begin
        #400000;
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        logic [3:0]  be;
        logic [31:0] a;
        logic        t;
        logic        r;
        void'($urandom(32'hd9b7));
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        bus(1'h1, 8'h10, 32'h1234_5678);
        for (int i = 0; i < 5; i++)
        begin
            bus(1'h0, 8'(4 * i), 32'h0);
            chk(rd, i == 2 ? 32'h8000_0000 : 32'h0);
        end
        // Every space and direction, then an unclaimed read, then a random one
        for (int i = 0; i < 6; i++)
        begin
            be = 4'($urandom_range(1, 15));
            a = $urandom;
            t = i < 4 ? i[1] : (i == 4 ? 1'h0 : 1'($urandom));
            r = i < 4 ? i[0] : (i == 4 ? 1'h1 : 1'($urandom));
            for (int b = 3; b >= 0; b--)
                if (t && be[b])
                    a[1:0] = 2'(b);
            lat <= 2'($urandom_range(0, 2));
            rdata <= $urandom;
            present <= (i != 4);
            @(posedge hclk);
            run(t, r, be, a, $urandom);
        end
        // Mastering off: own-type flush discards, other type is held until enabled
        for (int k = 0; k < 2; k++)
        begin
            f0 = frames;
            bus(1'h1, PCP_OFF_MSTCFG, k ? 32'h200 : 32'h400);
            bus_master_enable <= 1'h0;
            bus(1'h1, PCP_OFF_COMMAND, {24'h0, 4'hf, 1'h0, k[0], 2'h1});
            wait_ready();
            chk(frames, f0);
            bus(1'h0, PCP_OFF_DATA, 32'h0);
            chk(rd, ed);
            bus(1'h1, PCP_OFF_COMMAND, {24'h0, 4'hf, 1'h0, !k[0], 2'h1});
            repeat (80) @(posedge hclk);
            bus(1'h0, PCP_OFF_COMMAND, 32'h0);
            chk({31'h0, rd[CMD_READY_BIT]}, 32'h0);
            chk(frames, f0);
            bus_master_enable <= 1'h1;
            wait_ready();
            chk(frames, f0 + 1);
            ed = rdata;
        end
        report_and_stop();
    end
endmodule

// *** test/pcp_proxy_props.sv ***
// Concurrent checks on the proxy initiator's register port and link pins
module pcp_proxy_props
    import pcp_pkg::*;
#(
    parameter int DEVSEL_TIMEOUT = 5
) (
    // Clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // Register bus
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    input  wire logic                  hreadyout,
    input  wire logic [31:0]           hrdata,
    input  wire logic                  hresp,
    // Permission and link pins
    input  wire logic                  bus_master_enable,
    input  wire pcp_pkg::pcp_pci_in_s  pci_in,
    input  wire pcp_pkg::pcp_pci_out_s pci_out
);
    logic        dp_wr_reg;
    logic        dp_rd_reg;
    logic        pend_reg;
    logic [7:0]  dp_off_reg;
    logic [31:0] d_reg;
    logic [31:0] a_reg;
    logic [31:0] c_reg;
    wire logic   cmd_dp = dp_wr_reg && dp_off_reg == PCP_OFF_COMMAND;
    wire logic   c_io = c_reg[CMD_TYPE_BIT];
    wire logic   c_rd = c_reg[CMD_RDWR_BIT];
    wire logic [31:0] exp_addr = c_io ? a_reg : {a_reg[31:2], 2'h0};
    wire logic [3:0]  exp_code = c_io ? (c_rd ? PCP_BUS_IO_RD : PCP_BUS_IO_WR)
                                      : (c_rd ? PCP_BUS_CFG_RD : PCP_BUS_CFG_WR);

    // Shadow of software writes; pend marks a command not yet seen on the link
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr_reg  <= 1'h0;
            dp_rd_reg  <= 1'h0;
            pend_reg   <= 1'h0;
            dp_off_reg <= 8'h0;
            d_reg      <= 32'h0;
            a_reg      <= 32'h0;
            c_reg      <= 32'h0;
        end
        else
        begin
            dp_wr_reg  <= hsel && htrans[1] && hready && hwrite;
            dp_rd_reg  <= hsel && htrans[1] && hready && !hwrite;
            dp_off_reg <= haddr[7:0];
            if (dp_wr_reg && dp_off_reg == PCP_OFF_DATA)
                d_reg <= hwdata;
            if (dp_wr_reg && dp_off_reg == PCP_OFF_ADDRESS)
                a_reg <= hwdata;
            if (cmd_dp)
                c_reg <= hwdata;
            if (cmd_dp)
                pend_reg <= 1'h1;
            else if ($fell(pci_out.frame_n))
                pend_reg <= 1'h0;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence launch_s;
        $fell(pci_out.frame_n);
    endsequence
    sequence data_s;
        $rose(pci_out.frame_n) && pci_out.frame_oe;
    endsequence
    sequence cmd_wr_s;
        cmd_dp && bus_master_enable;
    endsequence
    sequence rd_cmd_s;
        dp_rd_reg && dp_off_reg == PCP_OFF_COMMAND;
    endsequence

    launch_by_cmd_a: assert property (launch_s |-> pend_reg)
        else $error("bus cycle started without a command write");
    launch_needs_master_a: assert property (launch_s |-> $past(bus_master_enable))
        else $error("bus cycle started while mastering disabled");
    addr_phase_a: assert property (launch_s |-> pci_out.ad == exp_addr && pci_out.ad_oe)
        else $error("address phase carries wrong address");
    bus_code_a: assert property (launch_s |-> pci_out.cbe_n == exp_code && pci_out.cbe_oe)
        else $error("address phase carries wrong command code");
    byte_lanes_a: assert property (data_s |-> pci_out.cbe_n == ~c_reg[CMD_BE_HI:CMD_BE_LO])
        else $error("data phase byte enables wrong");
    write_data_a: assert property (data_s and !c_rd |-> pci_out.ad == d_reg && pci_out.ad_oe)
        else $error("write data phase carries wrong data");
    read_turn_a: assert property (data_s and c_rd |-> !pci_out.ad_oe)
        else $error("read data phase still drives the data lines");
    ready_clear_a: assert property (cmd_wr_s ##[1:2] rd_cmd_s |-> !hrdata[CMD_READY_BIT])
        else $error("ready still set just after a command write");
    busy_flag_a: assert property (rd_cmd_s and pci_out.frame_oe |-> !hrdata[CMD_READY_BIT])
        else $error("ready reads set during a bus cycle");
    cycle_end_a: assert property (data_s |-> ##[1:200] !pci_out.frame_oe)
        else $error("bus cycle never finished");
endmodule

bind pcp_proxy pcp_proxy_props #(.DEVSEL_TIMEOUT(DEVSEL_TIMEOUT)) pcp_proxy_props_inst (.hclk,
    .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata,
    .hresp, .bus_master_enable, .pci_in, .pci_out);

// *** test/pcp_target_model.sv ***
// Behavioural link target answering single configuration and I/O cycles
module pcp_target_model
    import pcp_pkg::*;
(
    // Link clock and initiator pins
    input  wire logic                  lclk,
    input  wire pcp_pkg::pcp_pci_out_s pins,
    // Behaviour knobs
    input  wire logic                  present,
    input  wire logic [1:0]            lat,
    input  wire logic [31:0]           rdata,
    // Pins toward the initiator
    output logic                       trdy_n,
    output logic                       devsel_n,
    output logic                       stop_n,
    output logic [31:0]                ad,
    // What the target saw
    output logic [31:0]                got_addr,
    output logic [31:0]                got_wd,
    output logic [3:0]                 got_cmd,
    output logic [3:0]                 got_be,
    output int                         frames
);
    timeunit 1ns;
    timeprecision 1ns;
    int st = 0;
    int wt = 0;

    // Pulled-up controls idle high; stop is never used
    initial
    begin
        trdy_n = 1'h1;
        devsel_n = 1'h1;
        stop_n = 1'h1;
        ad = 32'h0;
        frames = 0;
    end

    // Act on the falling edge so answers settle before the initiator samples
    always @(negedge lclk)
    begin
        if (st == 0 && pins.frame_oe && !pins.frame_n)
        begin
            st = 1;
            got_addr = pins.ad;
            got_cmd = pins.cbe_n;
            frames++;
        end
        else if (st == 1 && !pins.irdy_n && present)
        begin
            if (wt < int'(lat))
                wt++;
            else
            begin
                devsel_n = 1'h0;
                trdy_n = 1'h0;
                got_be = ~pins.cbe_n;
                got_wd = pins.ad;
                ad = rdata;
                st = 2;
            end
        end
        else if ((st == 2 && pins.irdy_n) || (st == 1 && !pins.irdy_oe))
        begin
            // Released lines must not keep the old value
            devsel_n = 1'h1;
            trdy_n = 1'h1;
            ad = ~ad;
            st = 0;
            wt = 0;
        end
    end
endmodule
